// >>> pkg/monitor_cycle_sequencer_pkg.sv
// Functional notes
// (R1) Temperature result is 9-bit two's complement.
// (R2) Temperature limits compare upper eight bits only.
// (R3) Upper bits in value, LSB in config bit7.
// (R4) Half degree per LSB, signed code range.
// (R5) Voltage above high or below low flags.
// (R6) Overtemperature sets above hot, clears at hysteresis.
// (R7) Start=1 with clear=0 begins monitoring.
// (R8) Interrupt pin driven only when enabled.
// (R9) Channels in turn, core two first, temperature last.
// (R10) Each result stored automatically on completion.
// (R11) Cycle repeats until start bit written zero.
// (R12) Oscillator tick 22.5 kHz, seven slots.
// (R13) Monitoring start also starts fan measurement.
// (R14) Averaging takes sixteen conversions, stores mean.
// (R15) Test mode bit 7 selects averaging.
// (R16) Fan DAC code resets to all ones.
// (R17) Ten-bit voltage conversions, upper eight kept.
// (R18) Latched flags drive interrupt when enabled, unclear.
//
// Purpose: Constants shared by the monitoring cycle sequencer.
// Assumes: 200 MHz ref_clk, 8-bit register port behind the serial bus.
// Notes:   Offsets are byte register addresses seen by the serial bus.
package monitor_cycle_sequencer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 200_000_000; // Clock rate.
  localparam int OSC_FREQ_HZ     = 22_500;      // Multiplexer clock rate.
  localparam int OSC_TICK_CYCLES = (CLK_FREQ_HZ + OSC_FREQ_HZ / 2) / OSC_FREQ_HZ;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  localparam int       NUM_VCH   = 6;      // Voltage channels.
  localparam logic [2:0] TEMP_CH = 3'h6;   // Temperature slot, last in cycle.
  localparam logic [3:0] AVG_LAST = 4'hF;  // Last of sixteen averaged samples.

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TEST_MODE   = 8'h15;
  localparam logic [7:0] ADDR_DAC         = 8'h19;
  localparam logic [7:0] ADDR_VALUE_BASE  = 8'h20;
  localparam logic [7:0] ADDR_TEMP_VALUE  = 8'h27;
  localparam logic [7:0] ADDR_HIGH_BASE   = 8'h2B;
  localparam logic [7:0] ADDR_LOW_BASE    = 8'h2C;
  localparam logic [7:0] ADDR_HOT_LIMIT   = 8'h39;
  localparam logic [7:0] ADDR_HYST_LIMIT  = 8'h3A;
  localparam logic [7:0] ADDR_CONFIG      = 8'h40;
  localparam logic [7:0] ADDR_STATUS      = 8'h41;
  localparam logic [7:0] ADDR_TEMP_CONFIG = 8'h4B;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_START_BIT   = 0;
  localparam int CFG_INT_EN_BIT  = 1;
  localparam int CFG_INT_CLR_BIT = 3;
  localparam int TEST_AVG_BIT    = 7;
  localparam int TCFG_LSB_BIT    = 7;
  localparam logic [7:0] DAC_RESET   = 8'hFF;
  localparam logic [7:0] HIGH_RESET  = 8'hFF;
  localparam logic [7:0] LOW_RESET   = 8'h00;
  localparam logic [7:0] HOT_RESET   = 8'h50;
  localparam logic [7:0] HYST_RESET  = 8'h4B;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_e;

endpackage

// >>> src/monitor_cycle_sequencer.sv
// Purpose: Round-robin ADC sequencer with limit checks and fan DAC code.
// Assumes: Register port is the decoded output of the serial bus engine.
// Notes:   ADC answers each adc_start with one adc_done pulse later on.
`timescale 1ns/100ps
`default_nettype none
module monitor_cycle_sequencer #(
  parameter int unsigned TICK_DIV = monitor_cycle_sequencer_pkg::OSC_TICK_CYCLES
) (
  input  wire logic       ref_clk,        // 200 MHz clock.
  input  wire logic       resetn,         // Synchronous reset, active low.
  input  wire logic [7:0] reg_addr,       // Register address pointer.
  input  wire logic [7:0] reg_wdata,      // Write data.
  input  wire logic       reg_wr,         // Write strobe, one cycle.
  input  wire logic       reg_rd,         // Read strobe, one cycle.
  output logic      [7:0] reg_rdata,      // Read data, one cycle after reg_rd.
  output logic            adc_start,      // Conversion start pulse.
  output logic      [2:0] adc_channel,    // Channel to convert.
  input  wire logic       adc_done,       // Conversion finished pulse.
  input  wire logic [9:0] adc_result,     // Ten-bit result, temp in [8:0].
  output logic            fan_start,      // Fan measurement start pulse.
  output logic            irq_out,        // Interrupt level.
  output logic            irq_oe,         // Interrupt pin drive enable.
  output logic            overtemp,       // Overtemperature state.
  output logic      [7:0] dac_code,       // Fan DAC code.
  output logic            monitor_active  // Monitoring running.
);
  import monitor_cycle_sequencer_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [13:0] tick_cnt_reg, tick_cnt_next;   // Oscillator divider.
  logic        tick_reg, tick_next;           // 22.5 kHz enable pulse.
  seq_state_e  state_reg, state_next;         // Sequencer state.
  logic [2:0]  ch_reg, ch_next;               // Current channel.
  logic [3:0]  cnt_reg, cnt_next;             // Averaging sample count.
  logic [13:0] acc_reg, acc_next;             // Averaging accumulator.
  logic [7:0]  val_reg  [NUM_VCH];            // Voltage values.
  logic [7:0]  val_next [NUM_VCH];
  logic [7:0]  high_reg [NUM_VCH];            // High limits.
  logic [7:0]  high_next[NUM_VCH];
  logic [7:0]  low_reg  [NUM_VCH];            // Low limits.
  logic [7:0]  low_next [NUM_VCH];
  logic [8:0]  temp_reg, temp_next;           // Signed temperature.
  logic [6:0]  status_reg, status_next;       // Latched out-of-limit flags.
  logic        hot_reg, hot_next;             // Overtemperature state.
  logic [7:0]  cfg_reg, cfg_next;             // Configuration.
  logic [7:0]  test_reg, test_next;           // Test mode.
  logic [7:0]  dac_reg, dac_next;             // Fan DAC code.
  logic [7:0]  hot_lim_reg, hot_lim_next;     // Hot limit.
  logic [7:0]  hyst_reg, hyst_next;           // Hysteresis limit.
  logic        run_reg, run_next;             // Monitoring running.
  logic        fan_reg, fan_next;             // Fan start pulse.
  logic        start_reg, start_next;         // ADC start pulse.
  logic [7:0]  rdata_reg, rdata_next;         // Read data.
  logic        irq_reg, irq_next;             // Interrupt level.
  logic        irq_oe_reg, irq_oe_next;       // Interrupt drive enable.
  logic [13:0] sample;                        // Extended sample.
  logic [13:0] acc_sum;                       // Accumulator plus sample.
  logic [9:0]  avg10;                         // Final ten-bit result.
  logic        store;                         // Result stored this cycle.
  logic [7:0]  temp8;                         // Upper temperature bits.
  logic        cfg_wr;                        // Configuration write.
  logic        start_cmd;                     // Start request.

  assign cfg_wr    = reg_wr && (reg_addr == ADDR_CONFIG);
  // A start only counts when the clear bit is written low in the same write.
  assign start_cmd = cfg_wr && reg_wdata[CFG_START_BIT]
                     && !reg_wdata[CFG_INT_CLR_BIT]; // see (R7)

  // ----------------------------------------------------------------
  // Oscillator divider
  // ----------------------------------------------------------------
  // Free-running divider standing in for the slow on-chip oscillator.
  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 14'h0001;
    if (tick_cnt_reg == 14'(TICK_DIV - 1)) begin // see (R12)
      tick_cnt_next = 14'h0000;
      tick_next     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tick_cnt_reg <= 14'h0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and result store
  // ----------------------------------------------------------------
  // Temperature is sign-extended so the same accumulator serves both kinds.
  always_comb begin
    if (ch_reg == TEMP_CH) begin
      sample = {{5{adc_result[8]}}, adc_result[8:0]}; // see (R1), (R4)
    end else begin
      sample = {4'h0, adc_result};                    // see (R17)
    end
    acc_sum = acc_reg + sample;
    if (test_reg[TEST_AVG_BIT]) begin
      avg10 = acc_sum[13:4];                          // see (R14)
    end else begin
      avg10 = sample[9:0];
    end
    temp8 = avg10[8:1];                               // see (R2)
  end

  // One conversion per oscillator tick; averaging holds a channel 16 ticks.
  always_comb begin
    state_next  = state_reg;
    ch_next     = ch_reg;
    cnt_next    = cnt_reg;
    acc_next    = acc_reg;
    val_next    = val_reg;
    temp_next   = temp_reg;
    hot_next    = hot_reg;
    start_next  = 1'b0;
    store       = 1'b0;
    status_next = status_reg;
    // Write one to clear; a flag set in the same cycle still wins below.
    if (reg_wr && (reg_addr == ADDR_STATUS)) begin
      status_next = status_reg & ~reg_wdata[6:0];
    end
    case (state_reg)
      SEQ_IDLE: begin
        if (run_reg) begin
          state_next = SEQ_WAIT;
          ch_next    = 3'h0;                          // see (R9)
          cnt_next   = 4'h0;
          acc_next   = 14'h0000;
        end
      end
      SEQ_WAIT: begin
        if (tick_reg) begin
          start_next = 1'b1;                          // see (R12)
          state_next = SEQ_CONV;
        end
      end
      SEQ_CONV: begin
        if (adc_done) begin
          state_next = SEQ_WAIT;
          if (test_reg[TEST_AVG_BIT] && (cnt_reg != AVG_LAST)) begin // see (R15)
            cnt_next = cnt_reg + 4'h1;
            acc_next = acc_sum;
          end else begin
            store    = 1'b1;
            cnt_next = 4'h0;
            acc_next = 14'h0000;
            if (ch_reg == TEMP_CH) begin
              temp_next = avg10[8:0];                 // see (R10)
              ch_next   = 3'h0;                       // see (R9)
              if ($signed(temp8) > $signed(hot_lim_reg)) begin
                hot_next      = 1'b1;                 // see (R6)
                status_next[6] = 1'b1;                // see (R18)
              end else if ($signed(temp8) <= $signed(hyst_reg)) begin
                hot_next = 1'b0;                      // see (R6)
              end
            end else begin
              val_next[ch_reg] = avg10[9:2];          // see (R10)
              ch_next          = ch_reg + 3'h1;
              if ((avg10[9:2] > high_reg[ch_reg]) || (avg10[9:2] < low_reg[ch_reg])) begin
                status_next[ch_reg] = 1'b1;           // see (R5)
              end
            end
          end
        end
      end
      default: state_next = SEQ_IDLE;
    endcase
    // Stopping abandons any conversion in flight.
    if (!run_reg) begin
      state_next = SEQ_IDLE;                          // see (R11)
      start_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg  <= SEQ_IDLE;
      ch_reg     <= 3'h0;
      cnt_reg    <= 4'h0;
      acc_reg    <= 14'h0000;
      temp_reg   <= 9'h000;
      hot_reg    <= 1'b0;
      start_reg  <= 1'b0;
      status_reg <= 7'h00;
      for (int i = 0; i < NUM_VCH; i++) begin
        val_reg[i] <= ZERO_BYTE;
      end
    end else begin
      state_reg  <= state_next;
      ch_reg     <= ch_next;
      cnt_reg    <= cnt_next;
      acc_reg    <= acc_next;
      temp_reg   <= temp_next;
      hot_reg    <= hot_next;
      start_reg  <= start_next;
      status_reg <= status_next;
      val_reg    <= val_next;
    end
  end

  // ----------------------------------------------------------------
  // Host registers and readback
  // ----------------------------------------------------------------
  // Writes land the same cycle; reads answer one cycle after the strobe.
  always_comb begin
    cfg_next     = cfg_reg;
    test_next    = test_reg;
    dac_next     = dac_reg;
    hot_lim_next = hot_lim_reg;
    hyst_next    = hyst_reg;
    high_next    = high_reg;
    low_next     = low_reg;
    run_next     = run_reg;
    fan_next     = 1'b0;
    rdata_next   = rdata_reg;
    if (cfg_wr) begin
      cfg_next = reg_wdata;
      // Start with clear high leaves the run state alone.
      if (!reg_wdata[CFG_START_BIT]) begin
        run_next = 1'b0;                              // see (R11)
      end else if (start_cmd) begin
        run_next = 1'b1;                              // see (R7)
        fan_next = !run_reg;                          // see (R13)
      end
    end else if (reg_wr && (reg_addr == ADDR_TEST_MODE)) begin
      test_next = reg_wdata;                          // see (R15)
    end else if (reg_wr && (reg_addr == ADDR_DAC)) begin
      dac_next = reg_wdata;                           // see (R16)
    end else if (reg_wr && (reg_addr == ADDR_HOT_LIMIT)) begin
      hot_lim_next = reg_wdata;
    end else if (reg_wr && (reg_addr == ADDR_HYST_LIMIT)) begin
      hyst_next = reg_wdata;
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_VCH; i++) begin
        if (reg_addr == ADDR_HIGH_BASE + 8'(2 * i)) begin
          high_next[i] = reg_wdata;
        end
        if (reg_addr == ADDR_LOW_BASE + 8'(2 * i)) begin
          low_next[i] = reg_wdata;
        end
      end
    end
    if (reg_rd) begin
      rdata_next = ZERO_BYTE;                         // Unmapped reads zero.
      if (reg_addr == ADDR_TEMP_VALUE) begin
        rdata_next = temp_reg[8:1];                   // see (R3)
      end else if (reg_addr == ADDR_TEMP_CONFIG) begin
        rdata_next = {temp_reg[0], 7'h00};            // see (R3)
      end else if (reg_addr == ADDR_CONFIG) begin
        rdata_next = {cfg_reg[7:1], run_reg};
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_next = {hot_reg, status_reg};
      end else if (reg_addr == ADDR_TEST_MODE) begin
        rdata_next = test_reg;
      end else if (reg_addr == ADDR_DAC) begin
        rdata_next = dac_reg;
      end else if (reg_addr == ADDR_HOT_LIMIT) begin
        rdata_next = hot_lim_reg;
      end else if (reg_addr == ADDR_HYST_LIMIT) begin
        rdata_next = hyst_reg;
      end else begin
        for (int i = 0; i < NUM_VCH; i++) begin
          if (reg_addr == ADDR_VALUE_BASE + 8'(i)) begin
            rdata_next = val_reg[i];
          end
          if (reg_addr == ADDR_HIGH_BASE + 8'(2 * i)) begin
            rdata_next = high_reg[i];
          end
          if (reg_addr == ADDR_LOW_BASE + 8'(2 * i)) begin
            rdata_next = low_reg[i];
          end
        end
      end
    end
    // The pin is released unless enabled, so a shared line stays free.
    irq_oe_next = cfg_reg[CFG_INT_EN_BIT];            // see (R8)
    irq_next    = cfg_reg[CFG_INT_EN_BIT] && !cfg_reg[CFG_INT_CLR_BIT]
                  && (status_reg != 7'h00);           // see (R18)
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_reg     <= ZERO_BYTE;
      test_reg    <= ZERO_BYTE;
      dac_reg     <= DAC_RESET;                       // see (R16)
      hot_lim_reg <= HOT_RESET;
      hyst_reg    <= HYST_RESET;
      run_reg     <= 1'b0;
      fan_reg     <= 1'b0;
      rdata_reg   <= ZERO_BYTE;
      irq_reg     <= 1'b0;
      irq_oe_reg  <= 1'b0;
      for (int i = 0; i < NUM_VCH; i++) begin
        high_reg[i] <= HIGH_RESET;
        low_reg[i]  <= LOW_RESET;
      end
    end else begin
      cfg_reg     <= cfg_next;
      test_reg    <= test_next;
      dac_reg     <= dac_next;
      hot_lim_reg <= hot_lim_next;
      hyst_reg    <= hyst_next;
      run_reg     <= run_next;
      fan_reg     <= fan_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
      irq_oe_reg  <= irq_oe_next;
      high_reg    <= high_next;
      low_reg     <= low_next;
    end
  end

  assign reg_rdata      = rdata_reg;
  assign adc_start      = start_reg;
  assign adc_channel    = ch_reg;
  assign fan_start      = fan_reg;
  assign irq_out        = irq_reg;
  assign irq_oe         = irq_oe_reg;
  assign overtemp       = hot_reg;
  assign dac_code       = dac_reg;
  assign monitor_active = run_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // A start request from the idle state.
  sequence s_start_req;
    start_cmd && !run_reg;
  endsequence
  // Monitoring running together with a single fan start pulse.
  sequence s_started;
    monitor_active && fan_start ##1 !fan_start;
  endsequence

  AST_START: assert property (s_start_req |=> s_started) // see (R7)
    else $error("Start write did not start monitoring and fan.");
  AST_FAN_ONLY_ON_START: assert property (fan_start |-> $past(start_cmd)) // see (R13)
    else $error("Fan start without a start write.");
  AST_STOP: assert property (cfg_wr && !reg_wdata[CFG_START_BIT] |=> !monitor_active ##1
                             (state_reg == SEQ_IDLE)) // see (R11)
    else $error("Monitoring did not stop.");
  AST_IRQ_GATE: assert property (irq_out |-> irq_oe && $past(!cfg_reg[CFG_INT_CLR_BIT])) // see (R8)
    else $error("Interrupt asserted while disabled or cleared.");
  AST_DAC_RESET: assert property ($past(!resetn) |-> dac_code == DAC_RESET) // see (R16)
    else $error("DAC code not all ones after reset.");
  AST_WRAP: assert property (store && ch_reg == TEMP_CH && run_reg |=> ch_reg == 3'h0) // see (R9)
    else $error("Cycle did not wrap after temperature.");
  AST_STORE: assert property (store && ch_reg != TEMP_CH && run_reg
                              |=> val_reg[$past(ch_reg)] == $past(avg10[9:2])) // see (R10)
    else $error("Voltage result not stored.");
  AST_TEMP_READ: assert property (reg_rd && reg_addr == ADDR_TEMP_VALUE
                                  |=> reg_rdata == $past(temp_reg[8:1])) // see (R3)
    else $error("Temperature readback wrong.");
  AST_HOT: assert property (store && ch_reg == TEMP_CH && run_reg
                            && $signed(temp8) > $signed(hot_lim_reg) |=> overtemp) // see (R6)
    else $error("Overtemperature not flagged.");
  AST_LIMIT: assert property (store && ch_reg != TEMP_CH && run_reg
                              && avg10[9:2] > high_reg[ch_reg]
                              |=> status_reg[$past(ch_reg)]) // see (R5)
    else $error("High limit breach not latched.");
  AST_AVG: assert property (store && test_reg[TEST_AVG_BIT] |-> cnt_reg == AVG_LAST) // see (R14)
    else $error("Averaged result stored before sixteen samples.");
  AST_TICK: assert property (adc_start |-> $past(tick_reg) ##1 !adc_start) // see (R12)
    else $error("Conversion started off the oscillator tick.");

endmodule
`default_nettype wire

// >>> dv/adc_model.sv
// Purpose: Behavioural converter that answers each start after a fixed delay.
// Assumes: One conversion outstanding at a time, channel held meanwhile.
// Notes:   Outside the done pulse the result bus shows the inverse of its last value.
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  input  wire logic       ref_clk,     // Clock.
  input  wire logic       resetn,      // Synchronous reset, active low.
  input  wire logic       adc_start,   // Start pulse.
  input  wire logic [2:0] adc_channel, // Channel to convert.
  input  wire logic [9:0] volt_val,    // Voltage code returned.
  input  wire logic [8:0] temp_val,    // Temperature code returned.
  output var  logic       adc_done,    // Done pulse.
  output var  logic [9:0] adc_result   // Result, valid with done only.
);
  // --------
  // Conversion timer
  // --------
  int unsigned cnt = 0; // Cycles left in the conversion, zero when idle.
  // A stale bus is scrambled every cycle so the sequencer cannot use old data.
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    adc_result <= ~adc_result;
    if (!resetn) begin
      cnt <= 0;
      adc_result <= 10'h155;
    end else if (adc_start) begin
      cnt <= 5;
    end else if (cnt == 1) begin
      cnt <= 0;
      adc_done <= 1'b1;
      adc_result <= (adc_channel == 3'h6) ? {1'b0, temp_val} : volt_val;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Purpose: Self-checking bench for the monitoring cycle sequencer.
// Assumes: Short oscillator tick, converter model on the far side.
// Notes:   Every scenario task starts and ends one step after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import monitor_cycle_sequencer_pkg::*;
  localparam int unsigned TDIV = 20; // Short tick keeps the run brief.
  logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dac_code;
  logic [9:0] volt_val = 10'h2A8, adc_result;
  logic [8:0] temp_val = 9'h1F5;
  logic [2:0] adc_channel;
  logic adc_start, adc_done, fan_start, irq_out, irq_oe, overtemp, monitor_active;
  int bad_count = 0, tests_run = 0;
  logic [2:0] chans[$]; // Channels in the order they were started.
  always #2.5 ref_clk = ~ref_clk;
  // --------
  // Design and converter
  // --------
  monitor_cycle_sequencer #(.TICK_DIV(TDIV)) uut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_result(adc_result), .fan_start(fan_start), .irq_out(irq_out),
    .irq_oe(irq_oe), .overtemp(overtemp), .dac_code(dac_code),
    .monitor_active(monitor_active));
  adc_model conv (.ref_clk(ref_clk), .resetn(resetn), .adc_start(adc_start),
    .adc_channel(adc_channel), .volt_val(volt_val), .temp_val(temp_val),
    .adc_done(adc_done), .adc_result(adc_result));
  // Log every start so channel order can be judged afterwards.
  always @(posedge ref_clk) if (adc_start === 1'b1) chans.push_back(adc_channel);
  // --------
  // Helpers
  // --------
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk); #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk); #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk); #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk); #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // Bounded wait for n logged starts, then let the last result land.
  task automatic wait_conv(input int n);
    for (int i = 0; i < 20000 && chans.size() < n; i++) @(posedge ref_clk);
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    logic [7:0] d;
    check("dac_code", dac_code, 8'hFF);
    check("irq_oe_off", {7'h0, irq_oe}, 8'h00);
    rd(ADDR_DAC, d);
    check("dac_reg", d, 8'hFF);
    wr(ADDR_DAC, 8'h3C);
    check("dac_new", dac_code, 8'h3C);
    // A second reset after the DAC write, before monitoring starts, must bring the full-speed code back.
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check("dac_again", dac_code, 8'hFF);
  endtask
  task automatic t_cycle();
    logic [7:0] d;
    wr(ADDR_CONFIG, 8'h0B);
    repeat (3 * TDIV) @(posedge ref_clk);
    check("no_start", 8'(chans.size()), 8'h00);
    wr(ADDR_CONFIG, 8'h03);
    check("fan_start", {7'h0, fan_start}, 8'h01);
    check("active", {7'h0, monitor_active}, 8'h01);
    @(posedge ref_clk); #1;
    check("irq_oe", {7'h0, irq_oe}, 8'h01);
    wait_conv(7);
    for (int i = 0; i < 7; i++) check("chan", {5'h0, chans[i]}, 8'(i));
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_VALUE_BASE + 8'(i), d);
      check("volt", d, 8'hAA);
    end
    rd(ADDR_TEMP_VALUE, d);
    check("temp_hi", d, 8'hFA);
    rd(ADDR_TEMP_CONFIG, d);
    check("temp_lsb", d, 8'h80);
    check("irq_quiet", {7'h0, irq_out}, 8'h00);
  endtask
  task automatic t_limits();
    logic [7:0] d;
    logic [8:0] tv[3] = '{9'h0C1, 9'h099, 9'h097};
    logic ot[3] = '{1'b1, 1'b1, 1'b0};
    temp_val = 9'h0A1;
    wr(ADDR_HIGH_BASE, 8'hA9);
    wait_conv(chans.size() + 8);
    rd(ADDR_STATUS, d);
    check("status_hi", d, 8'h01);
    check("irq_set", {7'h0, irq_out}, 8'h01);
    wr(ADDR_HIGH_BASE, 8'hFF);
    wr(ADDR_LOW_BASE + 8'h02, 8'hAB);
    wait_conv(chans.size() + 8);
    wr(ADDR_STATUS, 8'hFF);
    wait_conv(chans.size() + 8);
    rd(ADDR_STATUS, d);
    check("status_lo", d, 8'h02);
    wr(ADDR_CONFIG, 8'h0B);
    // The interrupt level follows the stored configuration one edge later.
    @(posedge ref_clk);
    #1;
    check("irq_clr", {7'h0, irq_out}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      temp_val = tv[i];
      wait_conv(chans.size() + 8);
      check("overtemp", {7'h0, overtemp}, {7'h0, ot[i]});
    end
  endtask
  task automatic t_stop_avg();
    int n;
    logic [7:0] d;
    wr(ADDR_CONFIG, 8'h00);
    // A start launched on the stop edge itself is logged one edge later.
    @(posedge ref_clk);
    #1;
    n = chans.size();
    repeat (5 * TDIV) @(posedge ref_clk);
    check("stopped", 8'(chans.size() - n), 8'h00);
    wr(ADDR_TEST_MODE, 8'h80);
    volt_val = 10'h3FC;
    chans.delete();
    wr(ADDR_CONFIG, 8'h03);
    // Eight high then eight low samples: only a true mean stores 80.
    for (int i = 0; i < 20000 && chans.size() < 9; i++) @(posedge ref_clk);
    #1;
    volt_val = 10'h004;
    wait_conv(17);
    for (int i = 0; i < 17; i++) check("avg_chan", {5'h0, chans[i]}, 8'(i / 16));
    rd(ADDR_VALUE_BASE, d);
    check("avg_val", d, 8'h80);
  endtask
  // --------
  // Verdict, watchdog and main sequence
  // --------
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_cycle();
    t_limits();
    t_stop_avg();
    final_report();
  end
endmodule
`default_nettype wire
